// ===== core/chg_smbus_cmd.v
// smbus write-word command decoder and charger settings for the charger
`timescale 1ns/10ps
`include "chg_consts.vh"
// Behaviour
// R1: a transfer opens with sda falling while scl high, then the address.
// R2: answer the seven-bit address 0001001, bytes 12h write and 13h read.
// R3: command 12h write-word loads all sixteen data bits into the mode word.
// R4: while no cell is inserted the thermal stop enable bit is forced to one.
// R5: host clears thermal stop enable only after the cell is inserted.
// R6: command 15h sets voltage in millivolts; low four data bits ignored.
// R7: with d15 and d14 clear, voltage code is d13..d4, no over-range.
// R8: d15 or d14 set gives all-ones voltage code and over-range flag.
// R9: mode bit 0 set turns charging off and sets charge-off flag.
// R10: host writes 0 to mode bits 1,3 and 1 to 4,7,8,9,11-15.
// R11: mode bit 2 presets voltage FFFFh, current C0h, clears warm and alarm.
// R12: mode bit 5 clear lets cell insertion changes raise an event.
// R13: mode bit 6 clear lets supply loss changes raise an event.
// R14: mode bit 10 lets the warm thermistor status stop charging.
// R15: voltage setting resets to FFF0h and returns there with no cell.
// R16: command 14h loads the sixteen-bit current setting in milliamps.
// R17: range strap selects 1023, 2047 or 4095 mA maximum setting.
// R18: trickle gives setting 1..31 mA; 20h and above gives full 31 mA.
// R19: trickle off when voltage error low and voltage loop not inactive.
// R20: trickle zero on zero current, low voltage, alarm, thermal stop, off.
// R21: voltage loop inactive flag follows the clamp on the voltage node.
// R22: thermal stop is warm and stop enable and not under-range.
// R23: current setting resets to Ch and returns there with no cell.
// R24: settings change only after a full acknowledged write-word.
// R25: unknown command codes leave all settings unchanged.
module chg_smbus_cmd (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // serial bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // analog status inputs
  input wire cell_inserted,
  input wire supply_loss,
  input wire warm_detect,
  input wire thermal_sensor_underrange,
  input wire voltage_error_low,
  input wire clamp_active,
  input wire [1:0] range_sel,
  // alarm request from logic on this clock
  input wire alarm_request,
  // stored settings
  output reg [15:0] mode_word,
  output reg [15:0] voltage_setpoint_word,
  output reg [15:0] current_setpoint_word,
  // derived controls and status
  output reg [9:0] voltage_code,
  output reg voltage_over_range,
  output reg charge_off_flag,
  output reg thermal_stop,
  output reg thermal_sensor_warm,
  output reg alarm_lockout,
  output reg voltage_loop_inactive,
  output reg charge_enable,
  output reg [4:0] trickle_source,
  output reg [11:0] max_current_ma,
  // change events
  output reg insertion_event,
  output reg supply_loss_event
);
  // ****************************************
  // states
  // ****************************************
  localparam ST_IDLE = 4'b0001;
  localparam ST_RECV = 4'b0010;
  localparam ST_ACK = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  // ****************************************
  // input synchronisers
  // ****************************************
  wire [`CHG_NSYNC-1:0] sync_v;

  chg_sync #(
    .WIDTH(`CHG_NSYNC)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({range_sel, clamp_active, voltage_error_low,
      thermal_sensor_underrange, warm_detect, supply_loss,
      cell_inserted, sda_in, scl_in}),
    .sync_out(sync_v)
  );

  wire s_scl = sync_v[`CHG_S_SCL];
  wire s_sda = sync_v[`CHG_S_SDA];
  wire s_cell = sync_v[`CHG_S_CELL];
  wire s_loss = sync_v[`CHG_S_LOSS];
  wire s_warm = sync_v[`CHG_S_WARM];
  wire s_under = sync_v[`CHG_S_UNDER];
  wire s_vel = sync_v[`CHG_S_VEL];
  wire s_clamp = sync_v[`CHG_S_CLAMP];
  wire [1:0] s_sel = {sync_v[`CHG_S_SEL_HI], sync_v[`CHG_S_SEL_LO]};

  // ****************************************
  // bus condition detection
  // ****************************************
  reg scl_d;
  reg sda_d;
  reg cell_d;
  reg loss_d;

  wire scl_rise = s_scl & ~scl_d;
  wire scl_fall = ~s_scl & scl_d;
  // sda moving while scl high marks start or stop
  wire start_cond = scl_d & s_scl & sda_d & ~s_sda; // see R1
  wire stop_cond = scl_d & s_scl & ~sda_d & s_sda;

  always @(posedge clock) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      cell_d <= 1'b0;
      loss_d <= 1'b0;
    end else begin
      scl_d <= s_scl;
      sda_d <= s_sda;
      cell_d <= s_cell;
      loss_d <= s_loss;
    end
  end

  // ****************************************
  // byte receiver and acknowledge
  // ****************************************
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg [1:0] byte_idx;
  reg [7:0] rx_byte;
  reg [7:0] cmd_byte;
  reg [7:0] data_lo;
  reg wr_xfer;
  reg commit;

  wire addr_wr = (rx_byte == `CHG_ADDR_WR);
  wire addr_rd = (rx_byte == `CHG_ADDR_RD);
  wire [15:0] wr_data = {rx_byte, data_lo}; // see R3

  always @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      rx_byte <= 8'h00;
      cmd_byte <= 8'h00;
      data_lo <= 8'h00;
      wr_xfer <= 1'b0;
      commit <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      commit <= 1'b0;
      sda_out <= 1'b0;
      if (start_cond) begin
        // repeated start also restarts the address phase
        state <= ST_RECV; // see R1
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        wr_xfer <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        // a stop before the last acknowledge aborts the write
        state <= ST_IDLE; // see R24
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RECV: begin
            if (scl_rise && bit_cnt != `CHG_BYTE_BITS) begin
              rx_byte <= {rx_byte[6:0], s_sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `CHG_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (byte_idx == 2'h0) begin
                if (addr_wr || addr_rd) begin
                  wr_xfer <= addr_wr; // see R2
                  sda_oe <= 1'b1;
                  state <= ST_ACK;
                end else begin
                  state <= ST_WAIT;
                end
              end else begin
                if (byte_idx == 2'h1) begin
                  cmd_byte <= rx_byte;
                end
                if (byte_idx == 2'h2) begin
                  data_lo <= rx_byte;
                end
                sda_oe <= 1'b1;
                state <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              byte_idx <= byte_idx + 2'h1;
              // commit only once the high data byte is acknowledged
              if (byte_idx == `CHG_LAST_BYTE) begin
                commit <= 1'b1; // see R24
                state <= ST_WAIT;
              end else if (wr_xfer) begin
                state <= ST_RECV;
              end else begin
                // read data is not driven, the bus reads as ones
                state <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // settings registers
  // ****************************************
  wire wr_mode = commit && cmd_byte == `CHG_CMD_MODE; // see R25
  wire wr_curr = commit && cmd_byte == `CHG_CMD_CURR;
  wire wr_volt = commit && cmd_byte == `CHG_CMD_VOLT;
  wire por_preset = wr_mode && wr_data[`CHG_MB_POR];

  always @(posedge clock) begin
    if (sys_rst) begin
      mode_word <= `CHG_MODE_RST; // see R9
      voltage_setpoint_word <= `CHG_VOLT_RST; // see R15
      current_setpoint_word <= `CHG_CURR_RST; // see R23
    end else begin
      if (wr_mode) begin
        mode_word <= wr_data; // see R3
      end
      // other codes fall through and store nothing
      if (por_preset) begin
        voltage_setpoint_word <= `CHG_VOLT_POR; // see R11
        current_setpoint_word <= `CHG_CURR_POR; // see R11
      end else begin
        if (wr_volt) begin
          voltage_setpoint_word <= wr_data; // see R6
        end
        if (wr_curr) begin
          current_setpoint_word <= wr_data; // see R16
        end
      end
      // removal overrides a voltage, current or stop enable bit write in the same cycle
      if (!s_cell) begin
        voltage_setpoint_word <= `CHG_VOLT_RST; // see R15
        current_setpoint_word <= `CHG_CURR_RST; // see R23
        mode_word[`CHG_MB_HOT] <= 1'b1; // see R4
      end
    end
  end

  // ****************************************
  // latched status flags
  // ****************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      thermal_sensor_warm <= 1'b0;
      alarm_lockout <= 1'b0;
    end else begin
      // a new set wins over a clear in the same cycle
      if (s_warm) begin
        thermal_sensor_warm <= 1'b1;
      end else if (por_preset || !s_cell) begin
        thermal_sensor_warm <= 1'b0; // see R11
      end
      if (alarm_request) begin
        alarm_lockout <= 1'b1;
      end else if (por_preset || !s_cell) begin
        alarm_lockout <= 1'b0; // see R11
      end
    end
  end

  // ****************************************
  // derived controls
  // ****************************************
  wire next_over = voltage_setpoint_word[`CHG_VOR_HI] |
    voltage_setpoint_word[`CHG_VOR_LO];
  wire next_thermal_stop = thermal_sensor_warm &
    mode_word[`CHG_MB_HOT] & ~s_under; // see R22
  wire next_charge_enable = ~mode_word[`CHG_MB_OFF] &
    ~next_thermal_stop & ~alarm_lockout &
    (current_setpoint_word != `CHG_CURR_ZERO) &
    (voltage_setpoint_word >= `CHG_VOLT_MIN); // see R20
  // the clamp holding the voltage node keeps the trickle alive
  wire trickle_gate = next_charge_enable & ~(s_vel & ~s_clamp); // see R19
  reg [4:0] next_trickle;
  reg [11:0] next_max;

  always @* begin
    if (!trickle_gate) begin
      next_trickle = `CHG_TRK_OFF; // see R20
    end else if (current_setpoint_word >= `CHG_TRK_SAT) begin
      next_trickle = `CHG_TRK_FULL; // see R18
    end else begin
      next_trickle = current_setpoint_word[`CHG_TRK_HI:0]; // see R18
    end
  end

  always @* begin
    case (s_sel)
      `CHG_SEL_GND: next_max = `CHG_IMAX_GND; // see R17
      `CHG_SEL_OPEN: next_max = `CHG_IMAX_OPEN; // see R17
      `CHG_SEL_SUP: next_max = `CHG_IMAX_SUP; // see R17
      default: next_max = `CHG_IMAX_OPEN;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      voltage_code <= `CHG_VCODE_MAX;
      voltage_over_range <= 1'b1;
      charge_off_flag <= 1'b0;
      thermal_stop <= 1'b0;
      voltage_loop_inactive <= 1'b0;
      charge_enable <= 1'b0;
      trickle_source <= `CHG_TRK_OFF;
      max_current_ma <= `CHG_IMAX_GND;
      insertion_event <= 1'b0;
      supply_loss_event <= 1'b0;
    end else begin
      voltage_over_range <= next_over; // see R8
      if (next_over) begin
        voltage_code <= `CHG_VCODE_MAX; // see R8
      end else begin
        voltage_code <=
          voltage_setpoint_word[`CHG_VCODE_HI:`CHG_VCODE_LO]; // see R7
      end
      charge_off_flag <= mode_word[`CHG_MB_OFF]; // see R9
      thermal_stop <= next_thermal_stop; // see R14
      voltage_loop_inactive <= s_clamp; // see R21
      charge_enable <= next_charge_enable; // see R9
      trickle_source <= next_trickle;
      max_current_ma <= next_max;
      insertion_event <= (s_cell ^ cell_d) &
        ~mode_word[`CHG_MB_INS_MASK]; // see R12
      supply_loss_event <= (s_loss ^ loss_d) &
        ~mode_word[`CHG_MB_LOSS_MASK]; // see R13
    end
  end
endmodule

// ===== core/chg_sync.v
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module chg_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // asynchronous side
  input wire [WIDTH-1:0] async_in,
  // synchronised side
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // the first stage feeds only the second stage
  always @(posedge clock) begin
    if (sys_rst) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ===== pkg/chg_consts.vh
// constants for the charger command logic
`ifndef CHG_CONSTS_VH
`define CHG_CONSTS_VH
// ****************************************
// bus addresses and command codes
// ****************************************
`define CHG_ADDR_WR 8'h12
`define CHG_ADDR_RD 8'h13
`define CHG_CMD_MODE 8'h12
`define CHG_CMD_CURR 8'h14
`define CHG_CMD_VOLT 8'h15
`define CHG_BYTE_BITS 4'h8
`define CHG_LAST_BYTE 2'h3
// ****************************************
// reset and preset values
// ****************************************
`define CHG_MODE_RST 16'h0440
`define CHG_VOLT_RST 16'hFFF0
`define CHG_CURR_RST 16'h000C
`define CHG_VOLT_POR 16'hFFFF
`define CHG_CURR_POR 16'h00C0
// ****************************************
// mode word bit positions
// ****************************************
`define CHG_MB_OFF 0
`define CHG_MB_POR 2
`define CHG_MB_INS_MASK 5
`define CHG_MB_LOSS_MASK 6
`define CHG_MB_HOT 10
// ****************************************
// voltage and current fields
// ****************************************
`define CHG_VOR_HI 15
`define CHG_VOR_LO 14
`define CHG_VCODE_HI 13
`define CHG_VCODE_LO 4
`define CHG_VCODE_MAX 10'h3FF
`define CHG_VOLT_MIN 16'h0010
`define CHG_CURR_ZERO 16'h0000
`define CHG_TRK_SAT 16'h0020
`define CHG_TRK_FULL 5'h1F
`define CHG_TRK_OFF 5'h00
`define CHG_TRK_HI 4
// ****************************************
// range strap codes and limits in mA
// ****************************************
`define CHG_SEL_GND 2'h0
`define CHG_SEL_OPEN 2'h1
`define CHG_SEL_SUP 2'h2
`define CHG_IMAX_GND 12'h3FF
`define CHG_IMAX_OPEN 12'h7FF
`define CHG_IMAX_SUP 12'hFFF
// ****************************************
// synchroniser lanes
// ****************************************
`define CHG_NSYNC 10
`define CHG_S_SCL 0
`define CHG_S_SDA 1
`define CHG_S_CELL 2
`define CHG_S_LOSS 3
`define CHG_S_WARM 4
`define CHG_S_UNDER 5
`define CHG_S_VEL 6
`define CHG_S_CLAMP 7
`define CHG_S_SEL_LO 8
`define CHG_S_SEL_HI 9
`endif

// ===== tb/chg_cmd_sva.sv
// assertion checker for the charger command logic
`timescale 1ns/10ps
// ****************************************
// checker
// ****************************************
module chg_cmd_sva (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // watched inputs
  input wire cell_inserted,
  input wire voltage_error_low,
  input wire clamp_active,
  input wire [1:0] range_sel,
  // watched outputs
  input wire sda_out,
  input wire [15:0] mode_word,
  input wire [15:0] voltage_setpoint_word,
  input wire [15:0] current_setpoint_word,
  input wire [9:0] voltage_code,
  input wire voltage_over_range,
  input wire charge_off_flag,
  input wire thermal_stop,
  input wire alarm_lockout,
  input wire [4:0] trickle_source,
  input wire [11:0] max_current_ma,
  input wire insertion_event,
  input wire supply_loss_event
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  vcode_plain_a: assert property ($past(sys_rst) == 1'b0 &&
    !$past(voltage_setpoint_word[15]) && !$past(voltage_setpoint_word[14])
    |-> voltage_code == $past(voltage_setpoint_word[13:4])
    && !voltage_over_range) else $error("voltage code wrong");
  vcode_sat_a: assert property ($past(voltage_setpoint_word[15]) ||
    $past(voltage_setpoint_word[14]) |-> voltage_code == 10'h3FF
    && voltage_over_range) else $error("voltage not saturated");
  volt_removal_a: assert property (!cell_inserted [*5] |->
    voltage_setpoint_word == 16'hFFF0) else $error("voltage not reset");
  curr_removal_a: assert property (!cell_inserted [*5] |->
    current_setpoint_word == 16'h000C) else $error("current not reset");
  stop_forced_a: assert property (!cell_inserted [*5] |->
    mode_word[10]) else $error("stop enable not forced");
  off_flag_a: assert property ($rose(mode_word[0]) |->
    ##[0:2] charge_off_flag) else $error("charge off flag late");
  off_trickle_a: assert property (mode_word[0] [*4] |->
    trickle_source == 5'h00) else $error("trickle on while off");
  lock_trickle_a: assert property (alarm_lockout [*3] |->
    trickle_source == 5'h00) else $error("trickle on in lockout");
  comp_cut_a: assert property ((voltage_error_low && !clamp_active)
    [*5] |-> trickle_source == 5'h00) else $error("trickle not cut");
  trk_sat_a: assert property ((current_setpoint_word >= 16'h0020)
    [*4] |-> trickle_source == 5'h00 || trickle_source == 5'h1F)
    else $error("trickle not saturated");
  strap_gnd_a: assert property ((range_sel == 2'h0) [*4] |->
    max_current_ma == 12'h3FF) else $error("strap limit wrong");
  warm_gate_a: assert property (!mode_word[10] [*3] |->
    !thermal_stop) else $error("thermal stop while disabled");
  ins_mask_a: assert property (insertion_event |->
    !$past(mode_word[5]) ##1 !insertion_event)
    else $error("insertion event wrong");
  loss_mask_a: assert property (supply_loss_event |->
    !$past(mode_word[6]) ##1 !supply_loss_event)
    else $error("loss event wrong");
endmodule
bind chg_smbus_cmd chg_cmd_sva chk_u (.clock, .sys_rst, .cell_inserted,
  .voltage_error_low, .clamp_active, .range_sel, .sda_out, .mode_word,
  .voltage_setpoint_word, .current_setpoint_word, .voltage_code,
  .voltage_over_range, .charge_off_flag, .thermal_stop, .alarm_lockout,
  .trickle_source, .max_current_ma, .insertion_event, .supply_loss_event);

// ===== tb/chg_host.sv
// serial bus host model for the charger command logic
`timescale 1ns/10ps
// ****************************************
// host
// ****************************************
module chg_host (
  // clock
  input wire clock,
  // serial pins; the data line has a pull-up
  output reg scl,
  output reg sda_pull,
  input wire sda_line
);
  reg ack;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    ack = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // low and high phases of 4 clocks each: a 200 ns bus clock
  task cycle;
    begin
      tick(2);
      scl <= 1'b1;
      tick(4);
      ack = ~sda_line;
      scl <= 1'b0;
      tick(2);
    end
  endtask
  task xfer(input [7:0] a, input [7:0] c, input [15:0] d,
    input integer n, output [3:0] acks);
    reg [31:0] sh;
    integer k;
    integer j;
    begin
      sh = {a, c, d[7:0], d[15:8]};
      acks = 4'h0;
      sda_pull <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_pull <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
      for (k = 0; k < n; k = k + 1) begin
        for (j = 0; j < 8; j = j + 1) begin
          sda_pull <= ~sh[31];
          sh = sh << 1;
          cycle;
        end
        sda_pull <= 1'b0;
        cycle;
        acks = {acks[2:0], ack};
      end
      sda_pull <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_pull <= 1'b0;
      tick(4);
    end
  endtask
endmodule

// ===== tb/tb_top.sv
// testbench for the charger command logic
`timescale 1ns/10ps
// ****************************************
// bench
// ****************************************
module tb_top;
  reg clock, sys_rst, cell_inserted, supply_loss, warm_detect;
  reg thermal_sensor_underrange, voltage_error_low, clamp_active;
  reg alarm_request;
  reg [1:0] range_sel;
  reg [3:0] acks;
  wire scl_in, host_pull, sda_out, sda_oe, voltage_over_range;
  wire charge_off_flag, thermal_stop, thermal_sensor_warm, alarm_lockout;
  wire voltage_loop_inactive, charge_enable, insertion_event;
  wire supply_loss_event;
  wire [15:0] mode_word, voltage_setpoint_word, current_setpoint_word;
  wire [9:0] voltage_code;
  wire [4:0] trickle_source;
  wire [11:0] max_current_ma;
  wire sda_in = ~(host_pull | sda_oe);
  integer errors, n_tests, n_ins, n_loss, i;
  reg [11:0] imax [0:3];
  chg_smbus_cmd dut_u (.clock, .sys_rst, .scl_in, .sda_in, .sda_out,
    .sda_oe, .cell_inserted, .supply_loss, .warm_detect,
    .thermal_sensor_underrange, .voltage_error_low, .clamp_active,
    .range_sel, .alarm_request, .mode_word, .voltage_setpoint_word,
    .current_setpoint_word, .voltage_code, .voltage_over_range,
    .charge_off_flag, .thermal_stop, .thermal_sensor_warm, .alarm_lockout,
    .voltage_loop_inactive, .charge_enable, .trickle_source,
    .max_current_ma, .insertion_event, .supply_loss_event);
  chg_host host_u (.clock, .scl(scl_in), .sda_pull(host_pull),
    .sda_line(sda_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (insertion_event === 1'b1) n_ins <= n_ins + 1;
    if (supply_loss_event === 1'b1) n_loss <= n_loss + 1;
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task settle;
    repeat (8) @(posedge clock);
  endtask
  task wr(input [7:0] a, input [7:0] c, input [15:0] d, input integer n);
    begin
      host_u.xfer(a, c, d, n, acks);
      settle;
    end
  endtask
  task toggle_loss;
    begin
      supply_loss <= 1'b1;
      settle;
      supply_loss <= 1'b0;
      settle;
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d of %0d checks", errors, n_tests);
      if (errors == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // watchdog: the sequence needs well under 10000 clocks
  initial begin
    repeat (40000) @(posedge clock);
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    {cell_inserted, supply_loss, warm_detect, alarm_request} = 4'h0;
    {thermal_sensor_underrange, voltage_error_low, clamp_active} = 3'h0;
    range_sel = 2'h0;
    {errors, n_tests, n_ins, n_loss} = {32'h0, 32'h0, 32'h0, 32'h0};
    imax[0] = 12'h3FF;
    imax[1] = 12'h7FF;
    imax[2] = 12'hFFF;
    imax[3] = 12'h7FF;
    sys_rst = 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    settle;
    check(mode_word, 16'h0440);
    check(current_setpoint_word, 16'h000C);
    wr(8'h12, 8'h15, 16'h1234, 4);
    check(voltage_setpoint_word, 16'hFFF0);
    cell_inserted <= 1'b1;
    settle;
    wr(8'h12, 8'h15, 16'h12F0, 4);
    check(acks, 4'hF);
    check(voltage_setpoint_word, 16'h12F0);
    check({voltage_over_range, voltage_code}, 11'h12F);
    wr(8'h12, 8'h15, 16'h4000, 4);
    check({voltage_over_range, voltage_code}, 11'h7FF);
    wr(8'h12, 8'h14, 16'h0005, 4);
    check(current_setpoint_word, 16'h0005);
    check(trickle_source, 5'h05);
    wr(8'h12, 8'h14, 16'h0040, 4);
    check(trickle_source, 5'h1F);
    wr(8'h12, 8'h15, 16'h000F, 4);
    check({charge_enable, trickle_source}, 6'h00);
    wr(8'h12, 8'h15, 16'h4000, 4);
    voltage_error_low <= 1'b1;
    settle;
    check(trickle_source, 5'h00);
    clamp_active <= 1'b1;
    settle;
    check({voltage_loop_inactive, trickle_source}, 6'h3F);
    voltage_error_low <= 1'b0;
    clamp_active <= 1'b0;
    wr(8'h14, 8'h14, 16'h0007, 4);
    check(acks, 4'h0);
    wr(8'h13, 8'h14, 16'h0009, 4);
    check(acks, 4'h8);
    check(current_setpoint_word, 16'h0040);
    wr(8'h12, 8'h14, 16'h0007, 3);
    check(current_setpoint_word, 16'h0040);
    wr(8'h12, 8'h17, 16'h0007, 4);
    check(current_setpoint_word, 16'h0040);
    wr(8'h12, 8'h12, 16'hFB91, 4);
    check(mode_word, 16'hFB91);
    check({charge_off_flag, trickle_source}, 6'h20);
    check(charge_enable, 1'b0);
    wr(8'h12, 8'h12, 16'hFB90, 4);
    check({charge_off_flag, trickle_source}, 6'h1F);
    check(charge_enable, 1'b1);
    warm_detect <= 1'b1;
    settle;
    check(thermal_sensor_warm, 1'b1);
    check({thermal_stop, trickle_source}, 6'h1F);
    wr(8'h12, 8'h12, 16'hFF90, 4);
    check({thermal_stop, trickle_source}, 6'h20);
    thermal_sensor_underrange <= 1'b1;
    settle;
    check(thermal_stop, 1'b0);
    thermal_sensor_underrange <= 1'b0;
    warm_detect <= 1'b0;
    alarm_request <= 1'b1;
    @(posedge clock);
    alarm_request <= 1'b0;
    settle;
    check({alarm_lockout, trickle_source}, 6'h20);
    wr(8'h12, 8'h12, 16'hFB94, 4);
    check(voltage_setpoint_word, 16'hFFFF);
    check(current_setpoint_word, 16'h00C0);
    check({thermal_sensor_warm, alarm_lockout}, 2'h0);
    toggle_loss;
    check(n_loss, 16'h0002);
    wr(8'h12, 8'h12, 16'hFBD0, 4);
    toggle_loss;
    check(n_loss, 16'h0002);
    cell_inserted <= 1'b0;
    settle;
    check(voltage_setpoint_word, 16'hFFF0);
    check(current_setpoint_word, 16'h000C);
    check(mode_word[10], 1'b1);
    cell_inserted <= 1'b1;
    settle;
    check(n_ins, 16'h0003);
    wr(8'h12, 8'h12, 16'hFBF0, 4);
    cell_inserted <= 1'b0;
    settle;
    cell_inserted <= 1'b1;
    settle;
    check(n_ins, 16'h0003);
    for (i = 0; i < 4; i = i + 1) begin
      range_sel <= i[1:0];
      settle;
      check(max_current_ma, imax[i]);
    end
    give_verdict;
  end
endmodule
